// file: design/freq_divider.sv
// Programmable tick divider used for reference and feedback counters
`timescale 1ns/1ps
module freq_divider
    import synth_pkg::*;
#(
    parameter int W = 15
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Control
    input wire logic hold,
    input wire logic tick,
    input wire logic [W-1:0] ratio,
    // Divided output
    output logic pulse_ff
);
    logic [W-1:0] count_ff;
    logic [W-1:0] nxt_count;

    // Ratio zero behaves as one, so the divider never stalls
    assign nxt_count = count_ff + {{(W-1){1'b0}}, 1'b1};

    // Count ticks, pulse once per ratio; hold parks it in its load state
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || hold)
        begin
            count_ff <= '0;
            pulse_ff <= 1'b0;
        end
        else if (tick)
        begin
            if (nxt_count >= ratio)
            begin
                count_ff <= '0;
                pulse_ff <= 1'b1;
            end
            else
            begin
                count_ff <= nxt_count;
                pulse_ff <= 1'b0;
            end
        end
        else
        begin
            pulse_ff <= 1'b0;
        end
    end
endmodule : freq_divider

// file: design/synth_device.sv
// Synthesizer end: serial input, IF registers, counters, lock detect and resync
`timescale 1ns/1ps
`include "synth_regs.svh"
// Function
// - oscillator disable bit turns reference output off
// - master bits ten to seven select output
// - RF or IF control write clears selection
// - lock after 40 cycles under 15 ns
// - lock holds until new channel or 30 ns
// - control bits 100 load IF N divider
// - gain boost forces maximum pump current
// - feedback divides by P times B plus A
// - control bits 101 load IF R divider
// - doubler counts both reference edges
// - reference counter divides 1 to 32767
// - control bits 110 load IF control
// - counter reset bit holds IF counters
// - tri-state bit floats IF charge pump
// - power-down bit stops IF, keeps registers
// - power-down loads counters, floats pump, clears lock
// - bit seven sets phase detector polarity
// - bits eight to ten select pump current
// - resync enabled only by bits 15,14,11
// - resync delayed after channel writes
// - sections stay down until registers written
// - comparison rate is doubled reference over R
// - 24 bits shifted, moved on strobe rise
module synth_device
    import synth_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Serial link
    synth_link_if.device_end link,
    // Reference and IF oscillator pins
    input wire logic ref_in,
    input wire logic if_in,
    // Phase detector measurement
    input wire logic pd_cycle,
    input wire logic [7:0] phase_error_ns,
    // Control outputs
    output logic crystal_oscillator_disable_ff,
    output logic multiplexed_output_ff,
    output logic lock_detect_ff,
    output logic if_cp_tristate_ff,
    output logic [2:0] if_cp_current_ff,
    output logic if_pd_polarity_ff,
    output logic if_counter_hold_ff,
    output logic if_powered_ff,
    output logic rf_powered_ff,
    output logic resync_fire_ff,
    // Divided phase detector clocks
    output logic if_pd_ref_pulse,
    output logic if_pd_fb_pulse
);
    // Pins in bit order: serial clock, data, strobe, reference, IF input
    logic [4:0] meta_ff;
    logic [4:0] sync_ff;
    logic [4:0] prev_ff;
    logic [4:0] pins;
    serial_word_t shift_ff;
    serial_word_t master_ff;
    serial_word_t fb_ff;
    serial_word_t rd_ff;
    serial_word_t ic_ff;
    logic [6:0] written_ff;
    logic [3:0] mux_sel_ff;
    logic [5:0] lock_cnt_ff;
    logic [5:0] nxt_lock_cnt;
    logic resync_armed_ff;
    logic [14:0] resync_cnt_ff;
    logic [14:0] nxt_resync_cnt;
    logic sclk_rise;
    logic le_rise;
    logic ref_rise;
    logic ref_edge;
    logic if_rise;
    logic [2:0] addr;
    logic channel_write;
    logic if_off;
    logic if_hold;
    logic resync_en;
    logic [19:0] fb_ratio;
    logic ref_tick;

    assign pins = {if_in, ref_in, link.latch_strobe, link.serial_data, link.serial_clock};

    // Two-stage synchronisers; strobe idles high so it resets high
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            meta_ff <= 5'h04;
            sync_ff <= 5'h04;
            prev_ff <= 5'h04;
        end
        else
        begin
            meta_ff <= pins;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // Edge detection on synchronised pins only
    assign sclk_rise = sync_ff[0] && !prev_ff[0];
    assign le_rise = sync_ff[2] && !prev_ff[2];
    assign ref_rise = sync_ff[3] && !prev_ff[3];
    assign ref_edge = sync_ff[3] ^ prev_ff[3];
    assign if_rise = sync_ff[4] && !prev_ff[4];
    assign addr = shift_ff[2:0];
    assign channel_write = le_rise && (addr == `ADDR_RF_INT || addr == `ADDR_RF_RDIV);

    // shift on clock
    // Input register keeps shifting even while powered down
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            shift_ff <= `REG_RESET;
        end
        else if (sclk_rise)
        begin
            shift_ff <= {shift_ff[`SER_BITS-2:0], sync_ff[1]};
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            master_ff <= `REG_RESET;
            fb_ff <= `REG_RESET;
            rd_ff <= `REG_RESET;
            ic_ff <= `REG_RESET;
        end
        else if (le_rise)
        begin
            case (addr)
                `ADDR_MASTER: master_ff <= shift_ff;
                `ADDR_IF_FB: fb_ff <= shift_ff;
                `ADDR_IF_RDIV: rd_ff <= shift_ff;
                `ADDR_IF_CTRL: ic_ff <= shift_ff;
                default: master_ff <= master_ff;
            endcase
        end
    end

    // written tracking
    // Cleared only by reset; software power-down leaves it alone
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            written_ff <= `WRITTEN_RESET;
        end
        else if (le_rise && addr != 3'h7)
        begin
            written_ff[addr] <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            mux_sel_ff <= `MUX_RESET;
        end
        else if (le_rise && addr == `ADDR_MASTER)
        begin
            mux_sel_ff <= shift_ff[`MC_MUX_HI:`MC_MUX_LO];
        end
        else if (le_rise && (addr == `ADDR_RF_CTRL || addr == `ADDR_IF_CTRL))
        begin
            mux_sel_ff <= `MUX_RESET;
        end
    end

    assign if_off = !(&written_ff[6:3]) || ic_ff[`IC_PD];
    assign if_hold = if_off || ic_ff[`IC_CNT_RST];

    assign ref_tick = rd_ff[`RD_DBL] ? ref_edge : ref_rise;

    freq_divider #(.W(15)) u_ref_div (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .hold(if_hold),
        .tick(ref_tick),
        .ratio(rd_ff[`RD_R_HI:`RD_R_LO]),
        .pulse_ff(if_pd_ref_pulse)
    );

    // N equals P times B plus A, P being 8, 16, 32 or 64
    assign fb_ratio = 20'((20'(fb_ff[`FB_B_HI:`FB_B_LO]) << (3 + fb_ff[`FB_P_HI:`FB_P_LO]))
        + 20'(fb_ff[`FB_A_HI:`FB_A_LO]));

    freq_divider #(.W(20)) u_fb_div (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .hold(if_hold),
        .tick(if_rise),
        .ratio(fb_ratio),
        .pulse_ff(if_pd_fb_pulse)
    );

    assign nxt_lock_cnt = lock_cnt_ff + 6'h01;

    // lock reset
    // Narrow loops may false-lock around a cycle slip; loss of lock is reliable
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || if_off || channel_write)
        begin
            lock_cnt_ff <= 6'h00;
            lock_detect_ff <= 1'b0;
        end
        else if (pd_cycle)
        begin
            if (phase_error_ns > `UNLOCK_ERR_NS)
            begin
                lock_cnt_ff <= 6'h00;
                lock_detect_ff <= 1'b0;
            end
            else if (phase_error_ns < `LOCK_ERR_NS)
            begin
                if (nxt_lock_cnt >= `LOCK_COUNT)
                begin
                    lock_cnt_ff <= `LOCK_COUNT;
                    lock_detect_ff <= 1'b1;
                end
                else
                begin
                    lock_cnt_ff <= nxt_lock_cnt;
                end
            end
            else
            begin
                lock_cnt_ff <= 6'h00;
            end
        end
    end

    assign resync_en = ic_ff[`IC_RSY_A] && ic_ff[`IC_RSY_B] && ic_ff[`IC_RSY_C];
    assign nxt_resync_cnt = resync_cnt_ff + 15'h0001;

    // delayed resync
    // Delay counts undoubled reference cycles; a new channel write restarts it
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            resync_armed_ff <= 1'b0;
            resync_cnt_ff <= 15'h0000;
            resync_fire_ff <= 1'b0;
        end
        else if (channel_write && resync_en)
        begin
            resync_armed_ff <= 1'b1;
            resync_cnt_ff <= 15'h0000;
            resync_fire_ff <= 1'b0;
        end
        else if (resync_armed_ff && ref_rise)
        begin
            if (nxt_resync_cnt >= rd_ff[`RD_R_HI:`RD_R_LO])
            begin
                resync_armed_ff <= 1'b0;
                resync_fire_ff <= 1'b1;
            end
            else
            begin
                resync_cnt_ff <= nxt_resync_cnt;
                resync_fire_ff <= 1'b0;
            end
        end
        else
        begin
            resync_fire_ff <= 1'b0;
        end
    end

    // Registered control outputs
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            crystal_oscillator_disable_ff <= 1'b0;
            if_cp_tristate_ff <= 1'b1;
            if_cp_current_ff <= 3'h0;
            if_pd_polarity_ff <= 1'b0;
            if_counter_hold_ff <= 1'b1;
            if_powered_ff <= 1'b0;
            rf_powered_ff <= 1'b0;
        end
        else
        begin
            crystal_oscillator_disable_ff <= master_ff[`MC_XO_DIS];
            if_cp_tristate_ff <= ic_ff[`IC_CP_TRI] || if_off;
            if_cp_current_ff <= fb_ff[`FB_GAIN] ? `CP_CURRENT_MAX : ic_ff[`IC_CUR_HI:`IC_CUR_LO];
            if_pd_polarity_ff <= ic_ff[`IC_POL];
            if_counter_hold_ff <= if_hold;
            if_powered_ff <= !if_off;
            rf_powered_ff <= &written_ff[3:0];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            multiplexed_output_ff <= 1'b0;
        end
        else
        begin
            case (mux_sel_ff)
                `MUX_LOCK: multiplexed_output_ff <= lock_detect_ff;
                `MUX_IF_REF: multiplexed_output_ff <= if_pd_ref_pulse;
                `MUX_IF_FB: multiplexed_output_ff <= if_pd_fb_pulse;
                default: multiplexed_output_ff <= 1'b0;
            endcase
        end
    end
endmodule : synth_device

// file: design/synth_host.sv
// Host end: Wishbone slave that sends 24-bit words over the serial link
`timescale 1ns/1ps
`include "synth_regs.svh"
module synth_host
    import synth_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Serial link
    synth_link_if.host_end link
);
    host_state_t state_ff;
    serial_word_t word_ff;
    logic [4:0] bit_cnt_ff;
    logic [7:0] half_cnt_ff;
    logic sclk_ff;
    logic serial_data_ff;
    logic le_ff;
    logic req;
    logic start;
    logic half_done;

    assign link.serial_clock = sclk_ff;
    assign link.serial_data = serial_data_ff;
    assign link.latch_strobe = le_ff;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // A word written while busy is dropped; software polls status first
    assign start = req && wb_we_i && wb_adr_i == `WB_DATA && (&wb_sel_i[2:0])
        && state_ff == H_IDLE;
    assign half_done = half_cnt_ff == 8'(`SER_HALF_CYC - 1);

    // Bus answer one cycle after the request, dropped the next
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= req;
            case (wb_adr_i)
                `WB_DATA: wb_dat_o <= {8'h00, word_ff};
                `WB_STATUS: wb_dat_o <= {31'h00000000, state_ff != H_IDLE};
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // serial sequencer
    // Data changes with clock low, so the device samples it on the rise
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            state_ff <= H_IDLE;
            word_ff <= `REG_RESET;
            bit_cnt_ff <= 5'h00;
            half_cnt_ff <= 8'h00;
            sclk_ff <= 1'b0;
            serial_data_ff <= 1'b0;
            le_ff <= 1'b1;
        end
        else
        begin
            half_cnt_ff <= (state_ff == H_IDLE || half_done) ? 8'h00 : half_cnt_ff + 8'h01;
            case (state_ff)
                H_IDLE:
                begin
                    if (start)
                    begin
                        word_ff <= wb_dat_i[23:0];
                        serial_data_ff <= wb_dat_i[23];
                        bit_cnt_ff <= 5'h00;
                        le_ff <= 1'b0;
                        state_ff <= H_LOW;
                    end
                end
                H_LOW:
                begin
                    if (half_done)
                    begin
                        sclk_ff <= 1'b1;
                        state_ff <= H_HIGH;
                    end
                end
                H_HIGH:
                begin
                    if (half_done)
                    begin
                        sclk_ff <= 1'b0;
                        bit_cnt_ff <= bit_cnt_ff + 5'h01;
                        serial_data_ff <= word_ff[5'(`SER_BITS - 2) - bit_cnt_ff];
                        state_ff <= (bit_cnt_ff == 5'(`SER_BITS - 1)) ? H_LATCH : H_LOW;
                    end
                end
                H_LATCH:
                begin
                    if (half_done)
                    begin
                        le_ff <= 1'b1;
                        state_ff <= H_IDLE;
                    end
                end
                default: state_ff <= H_IDLE;
            endcase
        end
    end
endmodule : synth_host

// file: include/synth_link_if.sv
// Three-wire serial write link between host and synthesizer
`timescale 1ns/1ps
interface synth_link_if;
    logic serial_clock;
    logic serial_data;
    logic latch_strobe;
    modport host_end (output serial_clock, output serial_data, output latch_strobe);
    modport device_end (input serial_clock, input serial_data, input latch_strobe);
endinterface : synth_link_if

// file: include/synth_pkg.sv
// Types shared by both ends of the synthesizer link
package synth_pkg;
    typedef logic [23:0] serial_word_t;
    typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_LATCH} host_state_t;
endpackage : synth_pkg

// file: include/synth_regs.svh
// Register offsets, field positions, reset values and timing counts of the synthesizer link
`ifndef SYNTH_REGS_SVH
`define SYNTH_REGS_SVH

// Destination addresses in the three low control bits
`define ADDR_RF_INT 3'h0
`define ADDR_RF_RDIV 3'h1
`define ADDR_RF_CTRL 3'h2
`define ADDR_MASTER 3'h3
`define ADDR_IF_FB 3'h4
`define ADDR_IF_RDIV 3'h5
`define ADDR_IF_CTRL 3'h6

// Master register fields
`define MC_XO_DIS 6
`define MC_MUX_HI 10
`define MC_MUX_LO 7

// IF feedback divider fields
`define FB_A_HI 8
`define FB_A_LO 3
`define FB_B_HI 20
`define FB_B_LO 9
`define FB_P_HI 22
`define FB_P_LO 21
`define FB_GAIN 23

// IF reference divider fields
`define RD_R_HI 17
`define RD_R_LO 3
`define RD_DBL 18

// IF control fields
`define IC_CNT_RST 3
`define IC_CP_TRI 4
`define IC_PD 5
`define IC_POL 7
`define IC_CUR_HI 10
`define IC_CUR_LO 8
`define IC_RSY_A 15
`define IC_RSY_B 14
`define IC_RSY_C 11

// Reset values
`define REG_RESET 24'h000000
`define MUX_RESET 4'h0
`define WRITTEN_RESET 7'h00

// Multiplexed output selections
`define MUX_LOCK 4'h1
`define MUX_IF_REF 4'h2
`define MUX_IF_FB 4'h3

// Lock detection
`define LOCK_COUNT 6'h28
`define LOCK_ERR_NS 8'h0F
`define UNLOCK_ERR_NS 8'h1E

// Charge pump
`define CP_CURRENT_MAX 3'h7

// Serial framing and timing
`define SER_BITS 24
`define CLK_MHZ 50
`define SER_HALF_NS 25
`define SER_HALF_CYC ((`SER_HALF_NS * `CLK_MHZ + 999) / 1000)

// Host register offsets on the software bus
`define WB_DATA 4'h0
`define WB_STATUS 4'h4

`endif

// file: tb/if_synth_control_and_lock_detect_assertions.sv
// Link framing and lock detect checker for the synthesizer pair
`timescale 1ns/1ps
module if_synth_control_and_lock_detect_assertions
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Serial link
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic latch_strobe,
    // Lock detect and IF state
    input wire logic pd_cycle,
    input wire logic [7:0] phase_error_ns,
    input wire logic lock_detect_ff,
    input wire logic if_powered_ff,
    input wire logic if_cp_tristate_ff,
    input wire logic if_counter_hold_ff
);
    logic [4:0] bit_cnt_ff;
    logic [5:0] good_cnt_ff;
    logic sclk_q_ff;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Rising serial clocks inside one strobe-low frame
    always_ff @(posedge clk_sys)
    begin
        sclk_q_ff <= serial_clock;
        if (!reset_n || latch_strobe)
            bit_cnt_ff <= 5'h00;
        else if (serial_clock && !sclk_q_ff)
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
    end
    // Clean phase cycles; saturates so long locks never wrap to zero
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || (pd_cycle && phase_error_ns >= 8'h0F))
            good_cnt_ff <= 6'h00;
        else if (pd_cycle && good_cnt_ff != 6'h3F)
            good_cnt_ff <= good_cnt_ff + 6'h01;
    end
    sequence s_first_bit;
        !serial_clock [*2] ##1 serial_clock;
    endsequence
    sequence s_high_half;
        serial_clock [*2] ##1 !serial_clock;
    endsequence
    property p_idle_low;
        latch_strobe |-> !serial_clock;
    endproperty
    property p_frame_start;
        $fell(latch_strobe) |-> s_first_bit;
    endproperty
    property p_high_half;
        $rose(serial_clock) |-> s_high_half;
    endproperty
    property p_data_hold;
        serial_clock |-> $stable(serial_data);
    endproperty
    property p_frame_bits;
        $rose(latch_strobe) |-> bit_cnt_ff == 5'h18;
    endproperty
    property p_unlock;
        pd_cycle && phase_error_ns > 8'h1E |-> ##2 !lock_detect_ff;
    endproperty
    property p_lock_count;
        $rose(lock_detect_ff) |-> good_cnt_ff >= 6'h28;
    endproperty
    property p_pd_safe;
        (!if_powered_ff) [*3] |-> if_cp_tristate_ff && if_counter_hold_ff && !lock_detect_ff;
    endproperty
    a_idle_low: assert property (p_idle_low)
        else $error("serial clock high outside a frame");
    a_frame_start: assert property (p_frame_start)
        else $error("first serial clock not two cycles after strobe fall");
    a_high_half: assert property (p_high_half)
        else $error("serial clock high phase not two cycles");
    a_data_hold: assert property (p_data_hold)
        else $error("serial data moved while clock high");
    a_frame_bits: assert property (p_frame_bits)
        else $error("frame did not carry 24 bits");
    a_unlock: assert property (p_unlock)
        else $error("lock kept after large phase error");
    a_lock_count: assert property (p_lock_count)
        else $error("lock rose before 40 clean cycles");
    a_pd_safe: assert property (p_pd_safe)
        else $error("IF down but pump, counters or lock not safe");
endmodule : if_synth_control_and_lock_detect_assertions

// file: tb/if_synth_control_and_lock_detect_tb_top.sv
// Self-checking bench joining host and synthesizer ends over the serial link
`timescale 1ns/1ps
module if_synth_control_and_lock_detect_tb_top
    import synth_pkg::*;
;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ref_in = 1'b0, if_in = 1'b0, run = 1'b0;
    logic pd_cycle = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [7:0] perr = 8'h00;
    logic [31:0] wdat = 32'h0, dato, rdat;
    logic ack, xo, mux, lock, tri_s, hold, pol, ifp, rfp, fire, rpulse, fpulse;
    logic [2:0] cur;
    serial_word_t ctl_keep;
    int failures = 0, tests_run = 0, fires = 0, ref_rises = 0, if_rises = 0, ph = 0;
    int m_xo = 0, m_sel = 0, m_lock = 0, m_good = 0, m_gain = 0, m_ctl = 0, m_wr = 0;
    synth_link_if link();
    synth_host synth_host_inst (.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(dato), .wb_ack_o(ack), .link(link));
    synth_device synth_device_inst (.clk_sys(clk_sys), .reset_n(reset_n), .link(link),
        .ref_in(ref_in), .if_in(if_in), .pd_cycle(pd_cycle), .phase_error_ns(perr),
        .crystal_oscillator_disable_ff(xo), .multiplexed_output_ff(mux),
        .lock_detect_ff(lock), .if_cp_tristate_ff(tri_s), .if_cp_current_ff(cur),
        .if_pd_polarity_ff(pol), .if_counter_hold_ff(hold), .if_powered_ff(ifp),
        .rf_powered_ff(rfp), .resync_fire_ff(fire), .if_pd_ref_pulse(rpulse),
        .if_pd_fb_pulse(fpulse));
    if_synth_control_and_lock_detect_assertions if_synth_control_and_lock_detect_assertions_inst
    (
        .clk_sys(clk_sys), .reset_n(reset_n), .serial_clock(link.serial_clock),
        .serial_data(link.serial_data), .latch_strobe(link.latch_strobe),
        .pd_cycle(pd_cycle), .phase_error_ns(perr), .lock_detect_ff(lock),
        .if_powered_ff(ifp), .if_cp_tristate_ff(tri_s), .if_counter_hold_ff(hold)
    );
    // 50 MHz system clock
    always #10 clk_sys = ~clk_sys;
    // Pin toggles; counts land by NBA
    always @(posedge clk_sys)
    begin
        ph <= ph + 1;
        if (run && ph % 4 == 3)
        begin
            ref_in <= ~ref_in;
            if (!ref_in)
                ref_rises <= ref_rises + 1;
        end
        if (run && ph % 2 == 1)
        begin
            if_in <= ~if_in;
            if (!if_in)
                if_rises <= if_rises + 1;
        end
        if (fire === 1'b1)
            fires <= fires + 1;
    end
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : chk
    task automatic tmo(input int n);
        if (n >= 2000)
        begin
            failures++;
            $display("mismatch wait expected done seen timeout");
            end_sim();
        end
    endtask : tmo
    // Classic single cycle; request held until ack is sampled
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (ack !== 1'b1 && n < 2000);
        rdat = dato;
        cyc <= 1'b0;
        stb <= 1'b0;
        tmo(n);
    endtask : wb
    function automatic int ifpow();
        return (m_wr & 'h78) == 'h78 && m_ctl[5] == 1'b0;
    endfunction : ifpow
    task automatic check_all;
        chk("xo", xo, m_xo);
        chk("mux", mux, (m_sel == 1) ? m_lock : 0);
        chk("lock", lock, m_lock);
        chk("ifpow", ifp, ifpow());
        chk("rfpow", rfp, (m_wr & 'h0F) == 'h0F);
        chk("tristate", tri_s, m_ctl[4] | !ifpow());
        chk("hold", hold, m_ctl[3] | !ifpow());
        chk("pol", pol, m_ctl[7]);
        chk("cur", cur, m_gain ? 7 : (m_ctl >> 8) & 7);
    endtask : check_all
    // Register model keyed by the low three bits
    task automatic send(input serial_word_t w);
        int n = 0;
        wb(1'b1, 4'h0, {8'h00, w});
        do
        begin
            wb(1'b0, 4'h4, 32'h0);
            n++;
        end
        while (rdat[0] !== 1'b0 && n < 2000);
        tmo(n);
        repeat (6) @(posedge clk_sys);
        m_wr = m_wr | (1 << w[2:0]);
        case (w[2:0])
            3'h0, 3'h1: m_lock = 0;
            3'h2: m_sel = 0;
            3'h3: m_sel = w[10:7];
            3'h4: m_gain = w[23];
            3'h6: m_ctl = w;
            default: ;
        endcase
        m_xo = (w[2:0] == 3'h3) ? w[6] : m_xo;
        m_sel = (w[2:0] == 3'h6) ? 0 : m_sel;
        m_lock = ifpow() ? m_lock : 0;
        m_good = (m_lock == 0) ? 0 : m_good;
        check_all();
    endtask : send
    // Phase detector cycles with random errors in a range
    task automatic pd(input int lo, input int hi, input int n);
        int e;
        repeat (n)
        begin
            e = $urandom_range(hi, lo);
            @(posedge clk_sys);
            pd_cycle <= 1'b1;
            perr <= e[7:0];
            m_good = (e < 15) ? m_good + 1 : 0;
            m_lock = (m_good >= 40) ? 1 : ((e > 30) ? 0 : m_lock);
            @(posedge clk_sys);
            pd_cycle <= 1'b0;
        end
        repeat (3) @(posedge clk_sys);
        check_all();
    endtask : pd
    // Input rising edges between two divider pulses
    task automatic gap(input logic fb, output int d);
        int n = 0;
        int s = 0;
        for (int k = 0; k < 2; k++)
        begin
            do
            begin
                @(posedge clk_sys);
                n++;
            end
            while ((fb ? fpulse : rpulse) !== 1'b1 && n < 2000);
            d = (fb ? if_rises : ref_rises) - s;
            s = fb ? if_rises : ref_rises;
        end
        tmo(n);
    endtask : gap
    initial
    begin
        int d;
        int s;
        int n;
        void'($urandom(37987));
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        run <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check_all();
        wb(1'b0, 4'h8, 32'h0);
        chk("unmapped", rdat, 32'h0);
        $display("test reset done");
        // Bring-up: IF stays down until the last of 3..6 is written
        ctl_keep = 24'h00C886 | (serial_word_t'($urandom_range(6, 0)) << 8);
        send(24'h0000C3);
        send(24'h00041C);
        send(24'h000025);
        send(ctl_keep & 24'h0007FF);
        gap(1'b0, d);
        chk("rdiv", d, 4);
        gap(1'b1, d);
        chk("fbdiv", d, 19);
        send(24'h80041C);
        send(24'h00041C);
        $display("test bring-up done");
        // Lock thresholds, then clearing by control and channel writes
        pd(0, 14, 39);
        pd(0, 14, 1);
        pd(15, 30, 3);
        pd(31, 255, 1);
        pd(0, 14, 40);
        send(24'h0000C3);
        send(24'h000002);
        send(ctl_keep);
        send(24'h000000);
        $display("test lock done");
        // Resync delay in reference rises
        @(posedge clk_sys);
        run <= 1'b0;
        send(24'h000001);
        s = fires;
        d = ref_rises;
        n = 0;
        @(posedge clk_sys);
        run <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (fires == s && n < 2000);
        tmo(n);
        chk("resync", ref_rises - d, 4);
        send(ctl_keep & ~24'h000800);
        s = fires;
        send(24'h000000);
        repeat (100) @(posedge clk_sys);
        chk("nofire", fires - s, 0);
        $display("test resync done");
        // Counter hold, pump float and power-down, register contents kept
        pd(0, 14, 40);
        for (int b = 3; b < 6; b++)
        begin
            send(ctl_keep | (24'h000001 << b));
            send(ctl_keep);
        end
        send(24'h040025);
        gap(1'b0, d);
        chk("dbl", d, 2);
        $display("test power and doubler done");
        end_sim();
    end
endmodule : if_synth_control_and_lock_detect_tb_top
